/* File: design/hp_dac_i2c_ctrl.sv */
// What this block does
// [R1] i2c target, 8-bit register address, std/fast
// [R2] host idles bus over one clock between transfers
// [R3] write: addr, register, data, each acknowledged
// [R4] direction bit one reads, zero writes
// [R5] answer address byte 0x34 write, 0x35 read
// [R6] host ends read with nack then stop
// [R7] read without nack: hold line until start
// [R8] two read formats, incl. repeated start
// [R9] reg 1: left, right, chip enables, reset 0
// [R10] reg 1 bit1 read-only thermal flag
// [R11] reading reg 1 clears thermal flag
// [R12] reg 2: mutes set, 5-bit gain, 0xC0
// [R13] reg 3: left/right output float, reset 0
// [R14] host never writes test registers 0x04+
// [R15] host keeps word clock until chip off
// [R16] host should mute before format change
// [R17] reserved bits read zero, writes ignored
// [R18] ack address, register and write bytes

`include "hp_dac_i2c_params.svh"

module hp_dac_i2c_ctrl
  import hp_dac_i2c_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe,
  input  wire logic  thermal_alarm,
  output ctrl_t      ctrl,
  output logic       thermal_flag
);

  ////////////////////////////////////////////////////////////
  // declarations

  logic [1:0]  scl_sync_r;   // scl synchroniser
  logic [1:0]  sda_sync_r;   // sda synchroniser
  logic [1:0]  therm_sync_r; // thermal alarm synchroniser
  logic        scl_d_r;      // scl one cycle later
  logic        sda_d_r;      // sda one cycle later
  logic        scl_s;        // synced scl
  logic        sda_s;        // synced sda
  logic        scl_rise;     // scl rising edge
  logic        scl_fall;     // scl falling edge
  logic        start_det;    // start or repeated start
  logic        stop_det;     // stop condition

  i2c_state_t  state_r;      // engine state
  logic [3:0]  bit_cnt_r;    // bits of current byte
  logic [7:0]  shift_r;      // receive shifter
  logic [7:0]  tx_r;         // transmit shifter
  logic [7:0]  ptr_r;        // register pointer
  logic        sda_oe_r;     // pulls sda low when set
  logic        sda_out_r;    // level driven, always low

  logic        wr_stb;       // register write strobe
  logic        rd_clr;       // read of reg 1 taken
  logic [7:0]  rd_data;      // read mux
  logic        byte_done;    // eighth bit received

  ctrl_t       ctrl_r;       // control register bits
  logic        thermal_r;    // sticky thermal flag

  ////////////////////////////////////////////////////////////
  // input synchronisers, two flops each

  // first flop feeds only the second
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_sync_r   <= 2'b11;
      sda_sync_r   <= 2'b11;
      therm_sync_r <= 2'b00;
    end else begin
      scl_sync_r   <= {scl_sync_r[0], scl_in};
      sda_sync_r   <= {sda_sync_r[0], sda_in};
      therm_sync_r <= {therm_sync_r[0], thermal_alarm};
    end
  end

  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];

  // delayed copies for edge detection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////
  // bus events

  // edges of the oversampled serial clock
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  // data moving while clock high marks start/stop
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  // full byte shifted in, on the falling edge
  assign byte_done = scl_fall & (bit_cnt_r == `BITS_PER_BYTE);

  ////////////////////////////////////////////////////////////
  // read data mux

  // reserved positions read as zero
  always_comb begin
    rd_data = 8'h00;
    unique case (ptr_r)
      `REG_ENABLE_STAT: begin
        rd_data[`BIT_LEFT_ON]  = ctrl_r.left_driver_on;  // R9
        rd_data[`BIT_RIGHT_ON] = ctrl_r.right_driver_on; // R9
        rd_data[`BIT_THERMAL]  = thermal_r;              // R10
        rd_data[`BIT_CHIP_ON]  = ctrl_r.chip_on;         // R9
      end
      `REG_MUTE_VOL: begin
        rd_data[`BIT_LEFT_MUTE]         = ctrl_r.left_mute;  // R12
        rd_data[`BIT_RIGHT_MUTE]        = ctrl_r.right_mute; // R12
        rd_data[`GAIN_MSB:`GAIN_LSB]    = ctrl_r.gain_level; // R12
      end
      `REG_OUT_FLOAT: begin
        rd_data[`BIT_LEFT_FLOAT]  = ctrl_r.left_output_float;  // R13
        rd_data[`BIT_RIGHT_FLOAT] = ctrl_r.right_output_float; // R13
      end
      default: begin
        // test space and offset zero read zero
        rd_data = 8'h00; // R17
      end
    endcase
  end

  ////////////////////////////////////////////////////////////
  // serial engine

  // strobes come from the engine state and edges
  assign wr_stb = byte_done & (state_r == ST_WDATA);
  // a byte load of reg 1 toward the host
  assign rd_clr = scl_fall & (ptr_r == `REG_ENABLE_STAT) &
                  ((state_r == ST_RLOAD) ||
                   ((state_r == ST_ADDR_ACK) && shift_r[0]));

  // state, counters, shifters and line drive
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      sda_oe_r  <= 1'b0;
    end else if (start_det) begin
      // start or repeated start always restarts
      state_r   <= ST_ADDR; // R8
      bit_cnt_r <= 4'h0;
      sda_oe_r  <= 1'b0;    // R7
    end else if (stop_det && state_r != ST_RDATA && state_r != ST_RLOAD) begin
      // a stop inside a read byte is ignored
      state_r  <= ST_IDLE; // R7
      sda_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          // wait for a start
          sda_oe_r <= 1'b0;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          // shift bits in on the rising edge
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (byte_done) begin
            bit_cnt_r <= 4'h0;
            unique case (state_r)
              ST_ADDR: begin
                // match seven bits, direction in bit 0
                if (shift_r[7:1] == 7'(`TGT_ADDR_WR >> 1)) begin // R5
                  sda_oe_r <= 1'b1;                         // R18
                  state_r  <= ST_ADDR_ACK;
                end else begin
                  state_r  <= ST_IDLE;
                end
              end
              ST_REG: begin
                // 8-bit register address
                ptr_r    <= shift_r; // R1
                sda_oe_r <= 1'b1;    // R18
                state_r  <= ST_REG_ACK;
              end
              default: begin
                // data byte written by wr_stb
                sda_oe_r <= 1'b1;    // R18
                state_r  <= ST_WDATA_ACK;
              end
            endcase
          end
        end
        ST_ADDR_ACK: begin
          // end of ack slot picks the direction
          if (scl_fall) begin
            if (shift_r[0]) begin // R4
              // read from current pointer
              tx_r      <= rd_data;
              sda_oe_r  <= ~rd_data[7];
              ptr_r     <= ptr_r + 8'h01;
              bit_cnt_r <= 4'h0;
              state_r   <= ST_RDATA;
            end else begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_REG; // R3
            end
          end
        end
        ST_REG_ACK, ST_WDATA_ACK: begin
          // release and take further data bytes
          if (scl_fall) begin
            sda_oe_r  <= 1'b0;
            bit_cnt_r <= 4'h0;
            state_r   <= ST_WDATA;
            if (state_r == ST_WDATA_ACK) begin
              ptr_r <= ptr_r + 8'h01;
            end
          end
        end
        ST_RDATA: begin
          // drive the byte msb first
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (byte_done) begin
            // let the host answer
            sda_oe_r <= 1'b0;
            state_r  <= ST_RACK;
          end else if (scl_fall) begin
            tx_r     <= {tx_r[6:0], 1'b1};
            sda_oe_r <= ~tx_r[6];
          end
        end
        ST_RACK: begin
          // host answer sampled on the rising edge
          if (scl_rise) begin
            if (sda_s) begin
              state_r <= ST_IDLE; // R6
            end else begin
              state_r <= ST_RLOAD;
            end
          end
        end
        ST_RLOAD: begin
          // next byte once the ack clock falls
          if (scl_fall) begin
            tx_r      <= rd_data;
            sda_oe_r  <= ~rd_data[7];
            ptr_r     <= ptr_r + 8'h01;
            bit_cnt_r <= 4'h0;
            state_r   <= ST_RDATA;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // open drain: only ever drives low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // control registers

  // writes land at the pointer, reserved bits dropped
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r.left_driver_on     <= 1'(`RST_ENABLE_STAT >> `BIT_LEFT_ON);    // R9
      ctrl_r.right_driver_on    <= 1'(`RST_ENABLE_STAT >> `BIT_RIGHT_ON);   // R9
      ctrl_r.chip_on            <= 1'(`RST_ENABLE_STAT >> `BIT_CHIP_ON);    // R9
      ctrl_r.left_mute          <= 1'(`RST_MUTE_VOL >> `BIT_LEFT_MUTE);     // R12
      ctrl_r.right_mute         <= 1'(`RST_MUTE_VOL >> `BIT_RIGHT_MUTE);    // R12
      ctrl_r.gain_level         <= 5'(`RST_MUTE_VOL >> `GAIN_LSB);          // R12
      ctrl_r.left_output_float  <= 1'(`RST_OUT_FLOAT >> `BIT_LEFT_FLOAT);   // R13
      ctrl_r.right_output_float <= 1'(`RST_OUT_FLOAT >> `BIT_RIGHT_FLOAT);  // R13
    end else if (wr_stb) begin
      unique case (ptr_r)
        `REG_ENABLE_STAT: begin
          // thermal bit is read-only
          ctrl_r.left_driver_on  <= shift_r[`BIT_LEFT_ON];  // R9
          ctrl_r.right_driver_on <= shift_r[`BIT_RIGHT_ON]; // R9
          ctrl_r.chip_on         <= shift_r[`BIT_CHIP_ON];  // R9
        end
        `REG_MUTE_VOL: begin
          ctrl_r.left_mute  <= shift_r[`BIT_LEFT_MUTE];       // R12
          ctrl_r.right_mute <= shift_r[`BIT_RIGHT_MUTE];      // R12
          ctrl_r.gain_level <= shift_r[`GAIN_MSB:`GAIN_LSB];  // R12
        end
        `REG_OUT_FLOAT: begin
          ctrl_r.left_output_float  <= shift_r[`BIT_LEFT_FLOAT];  // R13
          ctrl_r.right_output_float <= shift_r[`BIT_RIGHT_FLOAT]; // R13
        end
        default: begin
          // other offsets hold nothing
          ctrl_r <= ctrl_r; // R17
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // thermal flag

  // sticky; a live alarm wins over the read clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      thermal_r <= 1'b0; // R10
    end else if (therm_sync_r[1]) begin
      thermal_r <= 1'b1; // R10
    end else if (rd_clr) begin
      thermal_r <= 1'b0; // R11
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign ctrl         = ctrl_r;
  assign thermal_flag = thermal_r;
  assign sda_oe       = sda_oe_r;
  assign sda_out      = sda_out_r;

endmodule

/* File: design/hp_dac_i2c_params.svh */
`ifndef HP_DAC_I2C_PARAMS_SVH
`define HP_DAC_I2C_PARAMS_SVH

// target address bytes, direction bit included
`define TGT_ADDR_WR     8'h34
`define TGT_ADDR_RD     8'h35

// register offsets
`define REG_ENABLE_STAT 8'h01
`define REG_MUTE_VOL    8'h02
`define REG_OUT_FLOAT   8'h03

// reset values
`define RST_ENABLE_STAT 8'h00
`define RST_MUTE_VOL    8'hC0
`define RST_OUT_FLOAT   8'h00

// enable_and_status fields
`define BIT_LEFT_ON     7
`define BIT_RIGHT_ON    6
`define BIT_THERMAL     1
`define BIT_CHIP_ON     0

// mute_and_volume fields
`define BIT_LEFT_MUTE   7
`define BIT_RIGHT_MUTE  6
`define GAIN_MSB        5
`define GAIN_LSB        1

// output_impedance_control fields
`define BIT_LEFT_FLOAT  1
`define BIT_RIGHT_FLOAT 0

// bits per byte before the acknowledge slot
`define BITS_PER_BYTE   4'h8

`endif

/* File: design/hp_dac_i2c_pkg.sv */
package hp_dac_i2c_pkg;

  // control outputs toward the analog side
  typedef struct packed {
    logic       left_driver_on;
    logic       right_driver_on;
    logic       chip_on;
    logic       left_mute;
    logic       right_mute;
    logic [4:0] gain_level;
    logic       left_output_float;
    logic       right_output_float;
  } ctrl_t;

  // serial engine states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_RLOAD
  } i2c_state_t;

endpackage

/* File: test/hp_dac_i2c_ctrl_sva.sv */
////////////////////////////////////////////////////////////
module hp_dac_i2c_ctrl_sva
  import hp_dac_i2c_pkg::*;
(
  input wire logic  sys_clk,
  input wire logic  rst_n,
  input wire logic  scl_in,
  input wire logic  sda_in,
  input wire logic  sda_out,
  input wire logic  sda_oe,
  input wire logic  thermal_alarm,
  input wire ctrl_t ctrl,
  input wire logic  thermal_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // preset values right after release
  a_reset_values: assert property ($rose(rst_n) |-> ctrl == 12'h180 && !sda_oe && !thermal_flag)
    else $error("control outputs not at preset after reset");
  a_sda_out_zero: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  // alarm held long enough must show in the flag
  a_thermal_set: assert property (thermal_alarm [*6] |-> thermal_flag)
    else $error("thermal flag missed a held alarm");
  a_thermal_cause: assert property ($rose(thermal_flag)
      |-> $past(thermal_alarm, 2) || $past(thermal_alarm, 3) || $past(thermal_alarm, 4))
    else $error("thermal flag set with no alarm");
  // clearing only on a byte load, never over a live alarm
  a_flag_clear: assert property ($fell(thermal_flag) |-> !scl_in && !$past(thermal_alarm, 3))
    else $error("thermal flag cleared at a wrong moment");
  a_ctrl_scl_low: assert property (!$stable(ctrl) |-> !scl_in)
    else $error("control changed while clock high");
  a_oe_scl_low: assert property (!$stable(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  a_oe_stands: assert property ($rose(scl_in) |=> $stable(sda_oe) [*8])
    else $error("data line not held through clock high");
endmodule
////////////////////////////////////////////////////////////
bind hp_dac_i2c_ctrl hp_dac_i2c_ctrl_sva hp_dac_i2c_ctrl_sva_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .thermal_alarm(thermal_alarm), .ctrl(ctrl), .thermal_flag(thermal_flag));

/* File: test/i2c_host.sv */
////////////////////////////////////////////////////////////
// bus controller; clock stands still between frames
module i2c_host (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus, line released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // start from idle, or repeated start from clock low
  task automatic start();
    #20 sda_pull = 1'b0;
    #20 scl = 1'b1;
    #20 sda_pull = 1'b1;
    #20 scl = 1'b0;
  endtask
  // stop, then idle longer than one clock period
  task automatic stop();
    #20 sda_pull = 1'b1;
    #20 scl = 1'b1;
    #20 sda_pull = 1'b0;
    #100;
  endtask
  // nine bits msb first; a one releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #20 sda_pull = ~tx[i];
      #20 scl = 1'b1;
      #20 rx[i] = sda_wire;
      #20 scl = 1'b0;
    end
  endtask
endmodule

/* File: test/testbench.sv */
////////////////////////////////////////////////////////////
module testbench import hp_dac_i2c_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       thermal_alarm = 1'b0;
  logic       scl, sda_pull, sda_out, sda_oe, thermal_flag;
  wire logic  sda = ~(sda_oe | sda_pull); // pull-up wire
  ctrl_t      ctrl;
  logic [8:0] rx;                         // last bits seen
  logic [7:0] mdl [0:3] = '{8'h00, 8'h00, 8'hc0, 8'h00};
  logic [7:0] mask [0:3] = '{8'h00, 8'hc1, 8'hfe, 8'h03};
  logic [7:0] ptr = 8'h00;                // model pointer
  logic [7:0] burst_d;                    // burst data byte
  logic       therm_m = 1'b0;             // model flag
  int         seed = 32'hf17d;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         cyc = 0;
  always #2 sys_clk = ~sys_clk;
  hp_dac_i2c_ctrl hp_dac_i2c_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .thermal_alarm(thermal_alarm), .ctrl(ctrl),
    .thermal_flag(thermal_flag));
  i2c_host i2c_host_i (.scl(scl), .sda_pull(sda_pull), .sda_wire(sda));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one byte, device must acknowledge
  task automatic send(input logic [7:0] b);
    i2c_host_i.xfer({b, 1'b1}, rx);
    check(12'h0, {11'h0, rx[0]});
  endtask
  // addresses 0x04 and up never written
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i2c_host_i.start();
    send(8'h34);
    send(a);
    send(d);
    i2c_host_i.stop();
    mdl[a[1:0]] = d & mask[a[1:0]];
    ptr = a + 8'h01;
    check({mdl[1][7:6], mdl[1][0], mdl[2][7:1], mdl[3][1:0]}, ctrl);
  endtask
  // read at pointer, optional register phase first
  task automatic rd(input logic [7:0] a, input logic two, input logic ack_last);
    logic [7:0] e;
    if (two) begin
      i2c_host_i.start();
      send(8'h34);
      send(a);
      ptr = a;
    end
    i2c_host_i.start();
    send(8'h35);
    i2c_host_i.xfer({8'hff, ack_last}, rx);
    e = (ptr < 8'h04) ? mdl[ptr[1:0]] | {6'h0, therm_m && ptr == 8'h01, 1'b0} : 8'h00;
    check({4'h0, e}, {4'h0, rx[8:1]});
    if (ptr == 8'h01)
      therm_m = 1'b0;
    ptr++;
    i2c_host_i.stop();
  endtask
  ////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 70000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    // host edges stay 1 ns past the clock from here on
    #1;
    for (int a = 1; a < 4; a++)
      rd(8'(a), 1'b1, 1'b1);
    $display("test preset done");
    repeat (12) begin
      wr({6'h0, 2'($random(seed))}, 8'($random(seed)));
      rd(ptr - 8'h01, 1'b1, 1'b1);
      rd(8'h00, 1'b0, 1'b1);
    end
    $display("test write read done");
    for (int i = 1; i < 4; i++) begin
      i2c_host_i.start();
      i2c_host_i.xfer({8'h34 ^ 8'(i << 1), 1'b1}, rx);
      check(12'h1, {11'h0, rx[0]});
      i2c_host_i.stop();
    end
    $display("test foreign address done");
    // burst write to mute_and_volume and output_impedance_control, then burst read back
    i2c_host_i.start();
    send(8'h34);
    send(8'h02);
    for (int i = 2; i < 4; i++) begin
      burst_d = 8'($random(seed));
      send(burst_d);
      mdl[i] = burst_d & mask[i];
    end
    i2c_host_i.stop();
    check({mdl[1][7:6], mdl[1][0], mdl[2][7:1], mdl[3][1:0]}, ctrl);
    i2c_host_i.start();
    send(8'h34);
    send(8'h02);
    i2c_host_i.start();
    send(8'h35);
    for (int i = 2; i < 4; i++) begin
      i2c_host_i.xfer({8'hff, i == 3}, rx);
      check({4'h0, mdl[i]}, {4'h0, rx[8:1]});
    end
    i2c_host_i.stop();
    ptr = 8'h04;
    $display("test burst done");
    @(posedge sys_clk) #1 thermal_alarm = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 check(12'h1, {11'h0, thermal_flag});
    thermal_alarm = 1'b0;
    therm_m = 1'b1;
    rd(8'h01, 1'b1, 1'b1);
    check(12'h0, {11'h0, thermal_flag});
    rd(8'h01, 1'b1, 1'b1);
    $display("test thermal done");
    rd(8'h03, 1'b1, 1'b0);
    check(12'h1, {11'h0, sda_oe});
    i2c_host_i.xfer(9'h1ff, rx);
    check(12'h0, {11'h0, sda_oe});
    i2c_host_i.stop();
    rd(8'h02, 1'b1, 1'b1);
    $display("test held line done");
    // mute first, then chip off before the word clock may stop
    wr(8'h02, 8'hc0);
    wr(8'h01, 8'h00);
    $display("test power down done");
    final_report();
  end
endmodule
